// file: rtl/resistance_frequency_converter.v
// one channel of the resistance-to-frequency converter: counters, sequencing, flags, registers
`include "rfc_defines.vh"

module resistance_frequency_converter #(
    parameter CNT_W = `RFC_CNT_W,
    parameter ADDR_W = `RFC_ADDR_W,
    parameter DATA_W = `RFC_DATA_W
) (
    input wire clk,
    input wire reset_n,
    input wire [ADDR_W-1:0] addr,
    input wire [DATA_W-1:0] wrData,
    input wire wrStrobe,
    input wire rdStrobe,
    output reg [DATA_W-1:0] rdData_q,
    input wire oscClk,
    input wire extClkPin,
    output reg refOsc_q,
    output reg sensorAOsc_q,
    output reg sensorBOsc_q,
    output reg acMode_q,
    output reg clockMonitorPin_q,
    output reg irqReq_q
);

    localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
    localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
    localparam [CNT_W-1:0] CNT_ALL1 = {CNT_W{1'b1}};

    function isWrite;
        input [ADDR_W-1:0] a;
        input [ADDR_W-1:0] idx;
        input strobe;
        begin
            isWrite = strobe && (a == idx);
        end
    endfunction

    // replaces the low 16 bits of a counter; the counter keeps its upper bits
    function [CNT_W-1:0] withLow;
        input [CNT_W-1:0] cur;
        input [DATA_W-1:0] d;
        begin
            withLow = {cur[CNT_W-1:16], d[15:0]};
        end
    endfunction

    // replaces the upper part of a counter; written after the low half
    function [CNT_W-1:0] withHigh;
        input [CNT_W-1:0] cur;
        input [DATA_W-1:0] d;
        begin
            withHigh = {d[CNT_W-17:0], cur[15:0]};
        end
    endfunction

    // upper part of a counter, zero-extended to a register word
    function [DATA_W-1:0] highWord;
        input [CNT_W-1:0] cur;
        begin
            highWord = {{(DATA_W+16-CNT_W){1'b0}}, cur[CNT_W-1:16]};
        end
    endfunction

    // a counter at all ones wraps on its next count
    function isAllOnes;
        input [CNT_W-1:0] v;
        begin
            isAllOnes = (v == CNT_ALL1);
        end
    endfunction

    reg [8:0] clkCfg_q;
    reg [8:0] ctl_q;
    reg [2:0] trg_q;
    reg [2:0] trg_d;
    reg [CNT_W-1:0] mc_q;
    reg [CNT_W-1:0] mc_d;
    reg [CNT_W-1:0] tc_q;
    reg [CNT_W-1:0] tc_d;
    reg [`RFC_INT_W-1:0] flags_q;
    reg [`RFC_INT_W-1:0] flags_d;
    reg [`RFC_INT_W-1:0] inte_q;
    reg [`RFC_INT_W-1:0] inte_d;
    reg [`RFC_INT_W-1:0] flagSet;
    reg [`RFC_INT_W-1:0] flagClr;
    reg [DATA_W-1:0] rdData_d;
    reg mcWrap;
    reg tcWrap;
    reg tbEnd;

    wire srcLevel;
    wire edgePulse;
    wire halfRate;
    wire channelEnable;
    wire contMode;
    wire eventSel;
    wire monDiv;
    wire acSelected;
    wire refRun;
    wire senRun;
    wire running;

    assign channelEnable = ctl_q[`RFC_CTL_ENABLE];
    assign contMode = ctl_q[`RFC_CTL_CONT];
    assign eventSel = ctl_q[`RFC_CTL_EVENT];
    assign monDiv = ctl_q[`RFC_CTL_MONDIV];
    // reserved mode codes behave as DC
    assign acSelected = (ctl_q[`RFC_CTL_MODE_HI:`RFC_CTL_MODE_LO] == `RFC_MODE_AC);
    assign refRun = trg_q[`RFC_TRG_REF];
    assign senRun = trg_q[`RFC_TRG_SENA] | trg_q[`RFC_TRG_SENB];
    assign running = refRun | senRun;

    osc_edge_detect u_edge (
        .clk(clk),
        .reset_n(reset_n),
        .oscClk(oscClk),
        .extClkPin(extClkPin),
        .eventSelect(eventSel),
        .active(running),
        .srcLevel_q(srcLevel),
        .edgePulse_q(edgePulse),
        .halfRate_q(halfRate)
    );

    // counting, automatic stops and start/abort control
    always @* begin
        mc_d = mc_q;
        tc_d = tc_q;
        trg_d = trg_q;
        flagSet = {`RFC_INT_W{1'b0}};
        mcWrap = edgePulse && isAllOnes(mc_q);
        tcWrap = isAllOnes(tc_q);
        // checking for zero as well catches a run started with the time base already at zero
        tbEnd = (tc_q == CNT_ONE) || (tc_q == CNT_ZERO);
        if (refRun) begin
            tc_d = tc_q + CNT_ONE;
            if (edgePulse) begin
                mc_d = mc_q + CNT_ONE;
            end
            if (!contMode && (mcWrap || tcWrap)) begin
                trg_d[`RFC_TRG_REF] = 1'b0;
                flagSet[`RFC_INT_REFDONE] = mcWrap;
                flagSet[`RFC_INT_TCOVF] = tcWrap;
            end
        end else if (senRun) begin
            tc_d = tc_q - CNT_ONE;
            if (edgePulse) begin
                mc_d = mc_q + CNT_ONE;
            end
            if (!contMode && (tbEnd || mcWrap)) begin
                trg_d[`RFC_TRG_SENA] = 1'b0;
                trg_d[`RFC_TRG_SENB] = 1'b0;
                if (tbEnd) begin
                    tc_d = CNT_ZERO;
                    flagSet[`RFC_INT_SENADONE] = trg_q[`RFC_TRG_SENA];
                    flagSet[`RFC_INT_SENBDONE] = trg_q[`RFC_TRG_SENB];
                end
                flagSet[`RFC_INT_MCOVF] = mcWrap;
            end
        end
        // software counter writes win over counting in the same cycle
        if (isWrite(addr, `RFC_REG_MCL, wrStrobe)) begin
            mc_d = withLow(mc_d, wrData);
        end
        if (isWrite(addr, `RFC_REG_MCH, wrStrobe)) begin
            mc_d = withHigh(mc_d, wrData);
        end
        if (isWrite(addr, `RFC_REG_TCL, wrStrobe)) begin
            tc_d = withLow(tc_d, wrData);
        end
        if (isWrite(addr, `RFC_REG_TCH, wrStrobe)) begin
            tc_d = withHigh(tc_d, wrData);
        end
        if (isWrite(addr, `RFC_REG_TRG, wrStrobe) && channelEnable) begin
            if (!running) begin
                // only one start is honoured; reference has priority if software breaks the rule
                if (wrData[`RFC_TRG_REF]) begin
                    trg_d = 3'h1;
                    tc_d = CNT_ZERO;
                end else if (wrData[`RFC_TRG_SENA]) begin
                    trg_d = 3'h2;
                    mc_d = CNT_ZERO;
                end else if (wrData[`RFC_TRG_SENB] && !acSelected) begin
                    trg_d = 3'h4;
                    mc_d = CNT_ZERO;
                end
            end else if ((trg_q & wrData[2:0]) == 3'h0) begin
                // abort: counters keep whatever they hold after this cycle
                trg_d = 3'h0;
            end
        end
        // dropping the enable stops the operating clock, so any run ends here
        if (!channelEnable) begin
            trg_d = 3'h0;
        end
    end

    // flags: a hardware set in the same cycle as a software clear wins
    always @* begin
        flagClr = {`RFC_INT_W{1'b0}};
        if (isWrite(addr, `RFC_REG_INTF, wrStrobe)) begin
            flagClr = wrData[`RFC_INT_W-1:0];
        end
        flags_d = (flags_q & ~flagClr) | flagSet;
    end

    // enables are plain read/write bits
    always @* begin
        inte_d = inte_q;
        if (isWrite(addr, `RFC_REG_INTE, wrStrobe)) begin
            inte_d = wrData[`RFC_INT_W-1:0];
        end
    end

    // read mux; unmapped addresses and reserved bits read zero
    always @* begin
        rdData_d = {DATA_W{1'b0}};
        if (rdStrobe) begin
            case (addr)
                `RFC_REG_CLK: rdData_d = {7'h00, clkCfg_q};
                `RFC_REG_CTL: rdData_d = {7'h00, ctl_q};
                `RFC_REG_TRG: rdData_d = {13'h0000, trg_q};
                `RFC_REG_MCL: rdData_d = mc_q[15:0];
                `RFC_REG_MCH: rdData_d = highWord(mc_q);
                `RFC_REG_TCL: rdData_d = tc_q[15:0];
                `RFC_REG_TCH: rdData_d = highWord(tc_q);
                `RFC_REG_INTF: rdData_d = {11'h000, flags_q};
                `RFC_REG_INTE: rdData_d = {11'h000, inte_q};
                default: rdData_d = {DATA_W{1'b0}};
            endcase
        end
    end

    // configuration registers
    always @(posedge clk) begin
        if (!reset_n) begin
            clkCfg_q <= `RFC_CLK_RESET;
            ctl_q <= `RFC_CTL_RESET;
            inte_q <= {`RFC_INT_W{1'b0}};
        end else begin
            // clock selection may only change while the channel is disabled
            if (isWrite(addr, `RFC_REG_CLK, wrStrobe) && !channelEnable) begin
                clkCfg_q <= wrData[8:0] & `RFC_CLK_MASK;
            end
            if (isWrite(addr, `RFC_REG_CTL, wrStrobe)) begin
                ctl_q <= wrData[8:0] & `RFC_CTL_MASK;
            end
            inte_q <= inte_d;
        end
    end

    // run control and both counters
    always @(posedge clk) begin
        if (!reset_n) begin
            trg_q <= 3'h0;
            mc_q <= CNT_ZERO;
            tc_q <= CNT_ZERO;
        end else begin
            trg_q <= trg_d;
            mc_q <= mc_d;
            tc_q <= tc_d;
        end
    end

    // interrupt flags
    always @(posedge clk) begin
        if (!reset_n) begin
            flags_q <= {`RFC_INT_W{1'b0}};
        end else begin
            flags_q <= flags_d;
        end
    end

    // read data stands for one cycle only, then drops to zero
    always @(posedge clk) begin
        if (!reset_n) begin
            rdData_q <= {DATA_W{1'b0}};
        end else begin
            rdData_q <= rdData_d;
        end
    end

    // pin-side outputs, each straight from a flip-flop
    always @(posedge clk) begin
        if (!reset_n) begin
            refOsc_q <= 1'b0;
            sensorAOsc_q <= 1'b0;
            sensorBOsc_q <= 1'b0;
            acMode_q <= 1'b0;
            clockMonitorPin_q <= 1'b0;
            irqReq_q <= 1'b0;
        end else begin
            refOsc_q <= trg_d[`RFC_TRG_REF];
            sensorAOsc_q <= trg_d[`RFC_TRG_SENA];
            sensorBOsc_q <= trg_d[`RFC_TRG_SENB];
            acMode_q <= acSelected;
            // monitor stays low between runs; it lags the source by two cycles
            clockMonitorPin_q <= running & (monDiv ? halfRate : srcLevel);
            irqReq_q <= |(flags_d & inte_d);
        end
    end

endmodule

// file: rtl/rfc_defines.vh
// register map, field positions and reset values of the resistance-to-frequency converter
`ifndef RFC_DEFINES_VH
`define RFC_DEFINES_VH

`define RFC_ADDR_W 4
`define RFC_DATA_W 16
`define RFC_CNT_W 24

// register word indices on the plain register port
`define RFC_REG_CLK 4'h0
`define RFC_REG_CTL 4'h1
`define RFC_REG_TRG 4'h2
`define RFC_REG_MCL 4'h3
`define RFC_REG_MCH 4'h4
`define RFC_REG_TCL 4'h5
`define RFC_REG_TCH 4'h6
`define RFC_REG_INTF 4'h7
`define RFC_REG_INTE 4'h8

// channel_clock_control: bit 8 debug run, 5:4 divider, 1:0 source
`define RFC_CLK_MASK 9'h133
`define RFC_CLK_RESET 9'h100

// channel_control_register fields
`define RFC_CTL_MASK 9'h1f1
`define RFC_CTL_RESET 9'h000
`define RFC_CTL_ENABLE 0
`define RFC_CTL_MODE_LO 4
`define RFC_CTL_MODE_HI 5
`define RFC_CTL_EVENT 6
`define RFC_CTL_CONT 7
`define RFC_CTL_MONDIV 8

// oscillation_mode_field encodings
`define RFC_MODE_DC 2'h0
`define RFC_MODE_AC 2'h1

// oscillation_trigger_register bits
`define RFC_TRG_REF 0
`define RFC_TRG_SENA 1
`define RFC_TRG_SENB 2

// interrupt flag / enable bit positions
`define RFC_INT_REFDONE 0
`define RFC_INT_SENADONE 1
`define RFC_INT_SENBDONE 2
`define RFC_INT_MCOVF 3
`define RFC_INT_TCOVF 4
`define RFC_INT_W 5

`endif

// file: rtl/osc_edge_detect.v
// selects the counted clock source, finds its rising edges and divides it by two
module osc_edge_detect (
    input wire clk,
    input wire reset_n,
    input wire oscClk,
    input wire extClkPin,
    input wire eventSelect,
    input wire active,
    output reg srcLevel_q,
    output reg edgePulse_q,
    output reg halfRate_q
);

    wire srcLevel_d;

    assign srcLevel_d = eventSelect ? extClkPin : oscClk;

    always @(posedge clk) begin
        if (!reset_n) begin
            srcLevel_q <= 1'b0;
            edgePulse_q <= 1'b0;
            halfRate_q <= 1'b0;
        end else begin
            srcLevel_q <= srcLevel_d;
            edgePulse_q <= srcLevel_d & ~srcLevel_q;
            // divider restarts low with every oscillation so the monitor phase is known
            if (!active) begin
                halfRate_q <= 1'b0;
            end else if (srcLevel_d & ~srcLevel_q) begin
                halfRate_q <= ~halfRate_q;
            end
        end
    end

endmodule

// file: verif/rfc_props.sv
// port assertions for one converter channel
module rfc_props (
    input wire clk,
    input wire reset_n,
    input wire [3:0] addr,
    input wire [15:0] wrData,
    input wire wrStrobe,
    input wire refOsc_q,
    input wire sensorAOsc_q,
    input wire sensorBOsc_q,
    input wire acMode_q,
    input wire clockMonitorPin_q,
    input wire irqReq_q
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    wire trgWr = wrStrobe && addr == 4'h2;
    wire intWr = wrStrobe && (addr == 4'h7 || addr == 4'h8);
    wire anyOsc = refOsc_q | sensorAOsc_q | sensorBOsc_q;
    sequence refAbort;
        refOsc_q && trgWr && !wrData[0];
    endsequence
    // the monitor stage lags the run enables, so allow a few idle cycles
    sequence idleRun;
        !anyOsc [*4];
    endsequence
    one_run_a: assert property ($onehot0({refOsc_q, sensorAOsc_q, sensorBOsc_q}))
        else $error("two oscillations at once");
    ref_start_a: assert property ($rose(refOsc_q) |-> $past(trgWr && wrData[0]))
        else $error("reference run without start write");
    sena_start_a: assert property ($rose(sensorAOsc_q) |-> $past(trgWr && wrData[1]))
        else $error("sensor A run without start write");
    senb_ac_a: assert property ($rose(sensorBOsc_q) |-> !$past(acMode_q))
        else $error("sensor B started in AC mode");
    ref_abort_a: assert property (refAbort |=> !refOsc_q)
        else $error("reference run not aborted");
    mon_idle_a: assert property (idleRun |-> !clockMonitorPin_q)
        else $error("monitor pin active while idle");
    irq_rise_a: assert property ($rose(irqReq_q) |-> $fell(anyOsc) || $past(wrStrobe)
        || $past(wrStrobe, 2))
        else $error("interrupt rose without cause");
    irq_fall_a: assert property ($fell(irqReq_q) |-> $past(intWr) || $past(intWr, 2))
        else $error("interrupt fell without flag or enable write");
    // the mode output is registered from the stored control word, two edges after the write
    mode_hold_a: assert property ($changed(acMode_q) |-> $past(wrStrobe && addr == 4'h1, 2))
        else $error("mode changed without control write");
endmodule

bind resistance_frequency_converter rfc_props chk (.clk, .reset_n, .addr, .wrData, .wrStrobe,
    .refOsc_q, .sensorAOsc_q, .sensorBOsc_q, .acMode_q, .clockMonitorPin_q, .irqReq_q);

// file: verif/osc_model.sv
// oscillator model: clock runs only while an oscillation enable is high
module osc_model #(
    parameter HALF = 3
) (
    input wire clk,
    input wire run,
    output logic oscClk
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    initial oscClk = 1'b0;
    always @(posedge clk) begin
        cnt <= (run && cnt < HALF - 1) ? cnt + 1 : 0;
        if (run && cnt == HALF - 1) oscClk <= ~oscClk;
    end
endmodule

// file: verif/resistance_frequency_converter_bench.sv
// self-checking bench for one converter channel
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module resistance_frequency_converter_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, reset_n = 0, wrStrobe = 0, rdStrobe = 0, extClkPin = 0, mon = 0;
    logic [3:0] addr = 0;
    logic [15:0] wrData = 0;
    wire [15:0] rdData_q;
    wire oscClk, refOsc_q, sensorAOsc_q, sensorBOsc_q, acMode_q, clockMonitorPin_q, irqReq_q;
    int n_fail = 0, cmp_count = 0, n, t1;
    always #5 clk = ~clk;
    resistance_frequency_converter dut (.clk, .reset_n, .addr, .wrData, .wrStrobe, .rdStrobe,
        .rdData_q, .oscClk, .extClkPin, .refOsc_q, .sensorAOsc_q, .sensorBOsc_q, .acMode_q,
        .clockMonitorPin_q, .irqReq_q);
    osc_model osc (.clk, .run(refOsc_q | sensorAOsc_q | sensorBOsc_q), .oscClk);
    task end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task wr(input [3:0] a, input [15:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
    endtask
    task rd(input [3:0] a, input [15:0] e);
        @(posedge clk);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clk);
        rdStrobe <= 1'b0;
        #1;
        `CHK(rdData_q, e)
    endtask
    // counts cycles until the run stops, and monitor pin toggles meanwhile
    task runLen(input int lim);
        n = 0;
        t1 = 0;
        #1;
        mon = clockMonitorPin_q;
        while ((refOsc_q | sensorAOsc_q | sensorBOsc_q) && n < lim) begin
            @(posedge clk);
            #1;
            n++;
            if (clockMonitorPin_q !== mon) t1++;
            mon = clockMonitorPin_q;
        end
        if (n == lim && lim > 90) begin
            n_fail++;
            end_sim;
        end
    endtask
    task preset(input [15:0] mcLow, input [15:0] tcLow);
        wr(4'h3, mcLow);
        wr(4'h4, 16'h00ff);
        wr(4'h5, tcLow);
        wr(4'h6, 16'h0000);
        wr(4'h7, 16'h001f);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd(4'h0, 16'h0100);
        rd(4'hf, 16'h0000);
        wr(4'h0, 16'hffff);
        rd(4'h0, 16'h0133);
        wr(4'h2, 16'h0001);
        rd(4'h2, 16'h0000);
        wr(4'h1, 16'h0001);
        wr(4'h0, 16'h0000);
        rd(4'h0, 16'h0133);
        wr(4'h8, 16'h001f);
        preset(16'hfffc, 16'h0000);
        wr(4'h2, 16'h0001);
        runLen(500);
        rd(4'h7, 16'h0001);
        `CHK(irqReq_q, 1'b1)
        rd(4'h3, 16'h0000);
        wr(4'h8, 16'h0000);
        rd(4'h7, 16'h0001);
        `CHK(irqReq_q, 1'b0)
        wr(4'h8, 16'h001f);
        preset(16'h0000, 16'h0014);
        rd(4'h7, 16'h0000);
        wr(4'h2, 16'h0002);
        runLen(500);
        `CHK(n, 20)
        rd(4'h7, 16'h0002);
        preset(16'h0000, 16'h0005);
        wr(4'h2, 16'h0004);
        runLen(500);
        `CHK(n, 5)
        rd(4'h7, 16'h0004);
        wr(4'h1, 16'h0000);
        wr(4'h1, 16'h0010);
        wr(4'h1, 16'h0011);
        `CHK(acMode_q, 1'b1)
        wr(4'h2, 16'h0004);
        rd(4'h2, 16'h0000);
        wr(4'h2, 16'h0002);
        rd(4'h7, 16'h0006);
        wr(4'h7, 16'h001f);
        wr(4'h2, 16'h0001);
        repeat (5) @(posedge clk);
        wr(4'h2, 16'h0000);
        rd(4'h5, 16'h0007);
        rd(4'h5, 16'h0007);
        wr(4'h1, 16'h0000);
        wr(4'h1, 16'h0081);
        preset(16'hfffe, 16'h0000);
        wr(4'h2, 16'h0001);
        runLen(60);
        `CHK(n, 60)
        `CHK(t1 > 15, 1'b1)
        wr(4'h1, 16'h0181);
        runLen(60);
        `CHK(t1 inside {[8:12]}, 1'b1)
        rd(4'h7, 16'h0000);
        wr(4'h2, 16'h0000);
        wr(4'h1, 16'h0000);
        wr(4'h1, 16'h0040);
        wr(4'h1, 16'h0041);
        preset(16'hfffe, 16'h0000);
        wr(4'h2, 16'h0001);
        runLen(40);
        `CHK(n, 40)
        repeat (4) begin
            @(posedge clk);
            extClkPin <= ~extClkPin;
            repeat (3) @(posedge clk);
        end
        runLen(500);
        rd(4'h7, 16'h0001);
        end_sim;
    end
endmodule
